// ### src/demosaic_pkg.sv
package demosaic_pkg;
  // ===========================================================
  // build-time defaults
  localparam int DEF_SAMPLE_BITS = 8;
  localparam int DEF_LINE_WIDTH = 1024;
  localparam int DEF_ADDR_BITS = 10;
  localparam int DEF_ALIGN = 0;
  localparam int DIM_BITS = 17;
  // ===========================================================
  // filter geometry and arithmetic
  localparam int WIN = 5;
  localparam int HALO = 2;
  localparam int LINESTORES = 4;
  localparam int COMP_BITS = 8;
  localparam int FRAC_BITS = 4;
  // ===========================================================
  // flow states
  typedef enum logic [1:0] {
    IDLE = 2'b01,
    RUN = 2'b10
  } flow_e;
endpackage

// ### src/demosaic_if.sv
`timescale 1ns/1ps
interface demosaic_if import demosaic_pkg::*; #(
  parameter int SAMPLE_BIT_WIDTH = DEF_SAMPLE_BITS
);
  logic [SAMPLE_BIT_WIDTH-1:0] inSample;
  logic inFrame;
  logic inLine;
  logic inValid;
  logic inReady;
  logic [DIM_BITS-1:0] frameWidth;
  logic [DIM_BITS-1:0] frameHeight;
  logic [3*COMP_BITS-1:0] outPixel;
  logic outFrame;
  logic outLine;
  logic outValid;
  logic outReady;

  modport dev (
    input inSample, inFrame, inLine, inValid, frameWidth, frameHeight, outReady,
    output inReady, outPixel, outFrame, outLine, outValid
  );
  modport ext (
    output inSample, inFrame, inLine, inValid, frameWidth, frameHeight, outReady,
    input inReady, outPixel, outFrame, outLine, outValid
  );
endinterface

// ### src/demosaic_dev.sv
`timescale 1ns/1ps
module demosaic_dev import demosaic_pkg::*; #(
  parameter int SAMPLE_BIT_WIDTH = DEF_SAMPLE_BITS,
  parameter int LINE_WIDTH = DEF_LINE_WIDTH,
  parameter int LINESTORE_ADDR_BITS = DEF_ADDR_BITS,
  parameter int SENSOR_ALIGN = DEF_ALIGN
) (
  input wire logic ref_clk,
  input wire logic resetn,
  demosaic_if.dev link,
  output logic frameActive
);
  localparam int MAXV = (1 << SAMPLE_BIT_WIDTH) - 1;
  localparam logic [1:0] ALIGN = 2'(SENSOR_ALIGN);

  typedef logic [SAMPLE_BIT_WIDTH-1:0] smp_t;

  flow_e state_q;
  logic [DIM_BITS-1:0] width_q, height_q, x_q, y_q;
  smp_t lineMem [LINESTORES][LINE_WIDTH];
  smp_t win_q [WIN][WIN];
  smp_t newCol [WIN];
  logic s1Val_q, s1Frame_q, s1Line_q;
  logic [1:0] s1Phase_q;
  logic outVal_q, outFrame_q, outLine_q;
  logic [3*COMP_BITS-1:0] outPixel_q;

  logic outFree, needIn, take, adv, start, active, colIn, rowIn, emit;
  logic [DIM_BITS-1:0] curX, curY, curW, curH, cx, cy;
  logic [LINESTORE_ADDR_BITS-1:0] addr;
  smp_t cur;

  // ===========================================================
  // helpers
  function automatic int tap(input int r, input int c);
    return int'(win_q[r][c]);
  endfunction

  function automatic logic [COMP_BITS-1:0] toComp(input int v);
    int s;
    s = v >>> FRAC_BITS;
    if (s < 0) begin
      s = 0;
    end
    if (s > MAXV) begin
      s = MAXV;
    end
    if (SAMPLE_BIT_WIDTH >= COMP_BITS) begin
      s = s >> (SAMPLE_BIT_WIDTH >= COMP_BITS ? SAMPLE_BIT_WIDTH - COMP_BITS : 0);
    end else begin
      s = s << (SAMPLE_BIT_WIDTH < COMP_BITS ? COMP_BITS - SAMPLE_BIT_WIDTH : 0);
    end
    return COMP_BITS'(s);
  endfunction

  // ===========================================================
  // flow control
  assign outFree = !outVal_q || link.outReady;
  assign needIn = (state_q == IDLE) || (x_q < width_q && y_q < height_q);
  assign link.inReady = outFree && needIn;
  assign take = link.inValid && link.inReady;
  assign start = (state_q == IDLE) && take && link.inFrame;
  assign active = (state_q == RUN) || start;
  always_comb begin
    if (state_q == RUN) begin
      adv = outFree && (!needIn || link.inValid);
    end else begin
      adv = take || (outFree && s1Val_q);
    end
  end

  // dimensions are taken with the frame marker sample
  assign curX = start ? '0 : x_q;
  assign curY = start ? '0 : y_q;
  assign curW = start ? link.frameWidth : width_q;
  assign curH = start ? link.frameHeight : height_q;
  assign colIn = curX < curW;
  assign rowIn = curY < curH;
  assign cur = (colIn && rowIn) ? link.inSample : '0;
  assign addr = curX[LINESTORE_ADDR_BITS-1:0];
  assign cx = curX - DIM_BITS'(HALO);
  assign cy = curY - DIM_BITS'(HALO);
  assign emit = active && curX >= DIM_BITS'(HALO) && curY >= DIM_BITS'(HALO);

  // ===========================================================
  // position walk over the frame plus a two-sample halo
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= IDLE;
      x_q <= '0;
      y_q <= '0;
      width_q <= '0;
      height_q <= '0;
    end else if (adv && active) begin
      if (start) begin
        state_q <= RUN;
        width_q <= link.frameWidth;
        height_q <= link.frameHeight;
      end
      if (curX == curW + DIM_BITS'(HALO - 1)) begin
        x_q <= '0;
        y_q <= curY + 1'b1;
        if (curY == curH + DIM_BITS'(HALO - 1)) begin
          state_q <= IDLE;
          y_q <= '0;
        end
      end else begin
        x_q <= curX + 1'b1;
        y_q <= curY;
      end
    end
  end

  assign frameActive = (state_q == RUN);

  // ===========================================================
  // line stores: four previous rows, no frame memory
  always_comb begin
    newCol[WIN-1] = cur;
    for (int k = 0; k < LINESTORES; k++) begin
      newCol[WIN-2-k] = (colIn && curY > DIM_BITS'(k)) ? lineMem[k][addr] : '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (adv && active && colIn) begin
      lineMem[0][addr] <= cur;
      for (int k = 1; k < LINESTORES; k++) begin
        lineMem[k][addr] <= lineMem[k-1][addr];
      end
    end
  end

  // ===========================================================
  // 5x5 window, zeroed at each line start
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int r = 0; r < WIN; r++) begin
        for (int c = 0; c < WIN; c++) begin
          win_q[r][c] <= '0;
        end
      end
    end else if (adv) begin
      for (int r = 0; r < WIN; r++) begin
        for (int c = 0; c < WIN - 1; c++) begin
          win_q[r][c] <= (curX == '0) ? '0 : win_q[r][c+1];
        end
        win_q[r][WIN-1] <= newCol[r];
      end
    end
  end

  // ===========================================================
  // stage one: centre position tags
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s1Val_q <= 1'b0;
      s1Frame_q <= 1'b0;
      s1Line_q <= 1'b0;
      s1Phase_q <= '0;
    end else if (adv) begin
      s1Val_q <= emit;
      s1Frame_q <= (cx == '0) && (cy == '0);
      s1Line_q <= (cx == '0);
      s1Phase_q <= {cy[0] ^ ALIGN[1], cx[0] ^ ALIGN[0]};
    end
  end

  // ===========================================================
  // polyphase kernels, scaled by sixteen
  int cC, nS, eW, n2S2, e2W2, dg;
  int gAt, hor, ver, dia, c16;
  logic [COMP_BITS-1:0] red, green, blue;

  always_comb begin
    cC = tap(2, 2);
    nS = tap(1, 2) + tap(3, 2);
    eW = tap(2, 1) + tap(2, 3);
    n2S2 = tap(0, 2) + tap(4, 2);
    e2W2 = tap(2, 0) + tap(2, 4);
    dg = tap(1, 1) + tap(1, 3) + tap(3, 1) + tap(3, 3);
    c16 = 16 * cC;
    gAt = 8 * cC + 4 * (nS + eW) - 2 * (n2S2 + e2W2);
    hor = 10 * cC + 8 * eW - 2 * e2W2 - 2 * dg + n2S2;
    ver = 10 * cC + 8 * nS - 2 * n2S2 - 2 * dg + e2W2;
    dia = 12 * cC + 4 * dg - 3 * (n2S2 + e2W2);
    // phase {row, col}: 00 blue site, 01 green in blue row, 10 green in red row, 11 red site
    case (s1Phase_q)
      2'b00: begin
        red = toComp(dia);
        green = toComp(gAt);
        blue = toComp(c16);
      end
      2'b01: begin
        red = toComp(ver);
        green = toComp(c16);
        blue = toComp(hor);
      end
      2'b10: begin
        red = toComp(hor);
        green = toComp(c16);
        blue = toComp(ver);
      end
      2'b11: begin
        red = toComp(c16);
        green = toComp(gAt);
        blue = toComp(dia);
      end
      default: begin
        red = '0;
        green = '0;
        blue = '0;
      end
    endcase
  end

  // ===========================================================
  // output register, one pixel per advance
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      outVal_q <= 1'b0;
      outFrame_q <= 1'b0;
      outLine_q <= 1'b0;
      outPixel_q <= '0;
    end else if (adv) begin
      outVal_q <= s1Val_q;
      outFrame_q <= s1Frame_q;
      outLine_q <= s1Line_q;
      outPixel_q <= {red, green, blue};
    end else if (link.outReady) begin
      outVal_q <= 1'b0;
    end
  end

  assign link.outValid = outVal_q;
  assign link.outFrame = outFrame_q;
  assign link.outLine = outLine_q;
  assign link.outPixel = outPixel_q;
endmodule

// ### src/demosaic_ext.sv
`timescale 1ns/1ps
module demosaic_ext import demosaic_pkg::*; #(
  parameter int SAMPLE_BIT_WIDTH = DEF_SAMPLE_BITS,
  parameter int LINESTORE_ADDR_BITS = DEF_ADDR_BITS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  demosaic_if.ext link,
  input wire logic [SAMPLE_BIT_WIDTH-1:0] srcSample,
  input wire logic srcValid,
  output logic srcReady,
  input wire logic [DIM_BITS-1:0] cfgWidth,
  input wire logic [DIM_BITS-1:0] cfgHeight,
  output logic [3*COMP_BITS-1:0] sinkPixel,
  output logic sinkFrame,
  output logic sinkLine,
  output logic sinkStrobe,
  input wire logic sinkReady,
  output logic resetAdvised,
  output logic lineTooLong
);
  localparam logic [DIM_BITS-1:0] STORE_LEN = DIM_BITS'(1 << LINESTORE_ADDR_BITS);

  logic inVal_q, frame_q, line_q, started_q;
  logic [SAMPLE_BIT_WIDTH-1:0] sample_q;
  logic [DIM_BITS-1:0] sx_q, sy_q, dimW_q, dimH_q, curW, curH;
  logic load, first;

  // ===========================================================
  // source side: one holding stage
  assign srcReady = !inVal_q || link.inReady;
  assign load = srcValid && srcReady;
  assign first = (sx_q == '0) && (sy_q == '0);
  assign curW = first ? cfgWidth : dimW_q;
  assign curH = first ? cfgHeight : dimH_q;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      inVal_q <= 1'b0;
      frame_q <= 1'b0;
      line_q <= 1'b0;
      sample_q <= '0;
      sx_q <= '0;
      sy_q <= '0;
      dimW_q <= '0;
      dimH_q <= '0;
      started_q <= 1'b0;
    end else if (load) begin
      inVal_q <= 1'b1;
      sample_q <= srcSample;
      frame_q <= first;
      line_q <= (sx_q == '0);
      if (first) begin
        dimW_q <= cfgWidth;
        dimH_q <= cfgHeight;
        started_q <= 1'b1;
      end
      if (sx_q == curW - 1'b1) begin
        sx_q <= '0;
        sy_q <= (sy_q == curH - 1'b1) ? '0 : sy_q + 1'b1;
      end else begin
        sx_q <= sx_q + 1'b1;
      end
    end else if (link.inReady) begin
      inVal_q <= 1'b0;
    end
  end

  // held stage stays put while the device stalls
  assign link.inValid = inVal_q;
  assign link.inSample = sample_q;
  assign link.inFrame = frame_q;
  assign link.inLine = line_q;
  assign link.frameWidth = dimW_q;
  assign link.frameHeight = dimH_q;

  // ===========================================================
  // configuration checks
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      resetAdvised <= 1'b0;
      lineTooLong <= 1'b0;
    end else begin
      if (started_q && (cfgWidth != dimW_q || cfgHeight != dimH_q)) begin
        resetAdvised <= 1'b1;
      end
      lineTooLong <= cfgWidth > STORE_LEN;
    end
  end

  // ===========================================================
  // sink side
  assign link.outReady = sinkReady;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sinkPixel <= '0;
      sinkFrame <= 1'b0;
      sinkLine <= 1'b0;
      sinkStrobe <= 1'b0;
    end else begin
      sinkStrobe <= link.outValid && link.outReady;
      if (link.outValid && link.outReady) begin
        sinkPixel <= link.outPixel;
        sinkFrame <= link.outFrame;
        sinkLine <= link.outLine;
      end
    end
  end
endmodule

// ### sim/demosaic_asserts.sv
`timescale 1ns/1ps
module demosaic_asserts import demosaic_pkg::*; #(
  parameter int SAMPLE_BIT_WIDTH = DEF_SAMPLE_BITS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [SAMPLE_BIT_WIDTH-1:0] inSample,
  input wire logic inFrame,
  input wire logic inLine,
  input wire logic inValid,
  input wire logic inReady,
  input wire logic [DIM_BITS-1:0] frameWidth,
  input wire logic [3*COMP_BITS-1:0] outPixel,
  input wire logic outFrame,
  input wire logic outLine,
  input wire logic outValid,
  input wire logic outReady
);
  // ===========================================================
  // helper state
  logic sawFrame_q;
  logic seenIn_q;
  logic [DIM_BITS-1:0] colCnt_q;
  logic [DIM_BITS-1:0] width_q;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sawFrame_q <= 1'h0;
      seenIn_q <= 1'h0;
    end else if (inValid && inReady) begin
      seenIn_q <= 1'h1;
      if (inFrame) begin
        sawFrame_q <= 1'h1;
      end
    end
  end
  // pixels seen since the last line marker, and the width of the output frame
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      colCnt_q <= '0;
      width_q <= '0;
    end else if (outValid && outReady) begin
      colCnt_q <= outLine ? DIM_BITS'(1) : colCnt_q + DIM_BITS'(1);
      if (outFrame) begin
        width_q <= frameWidth;
      end
    end
  end
  // ===========================================================
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  out_hold_a: assert property (
    outValid && !outReady |=> outValid && $stable(outPixel) && $stable(outFrame) && $stable(outLine))
    else $error("output changed before it was taken");
  in_hold_a: assert property (
    inValid && !inReady |=> inValid && $stable(inSample) && $stable(inFrame) && $stable(inLine))
    else $error("input changed before it was taken");
  reset_quiet_a: assert property (
    $rose(resetn) |-> !outValid && !inValid)
    else $error("valid high right after reset");
  frame_line_a: assert property (
    outValid && outFrame |-> outLine)
    else $error("frame marker without line marker");
  frame_seen_a: assert property (
    outValid |-> sawFrame_q)
    else $error("output before any input frame");
  first_in_a: assert property (
    inValid && !seenIn_q |-> inFrame && inLine)
    else $error("first sample lacks markers");
  in_marks_a: assert property (
    inValid && inFrame |-> inLine)
    else $error("input frame marker without line marker");
  line_len_a: assert property (
    outValid && outReady && outLine && !outFrame |-> colCnt_q == width_q)
    else $error("output line length wrong");
endmodule

// ### sim/test_bayer_demosaic_filter.sv
`timescale 1ns/1ps
module test_bayer_demosaic_filter import demosaic_pkg::*;
;
  // ===========================================================
  // signals
  localparam int AB = 5;
  localparam logic [7:0] RV = 8'hc0;
  localparam logic [7:0] GV = 8'h60;
  localparam logic [7:0] BV = 8'h20;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] srcSample = 8'h00;
  logic srcValid = 1'h0;
  logic sinkReady = 1'h1;
  logic stallMode = 1'h0;
  logic [DIM_BITS-1:0] cfgWidth = 17'h00010;
  logic [DIM_BITS-1:0] cfgHeight = 17'h00010;
  logic srcReady, sinkFrame, sinkLine, sinkStrobe, resetAdvised, lineTooLong, frameActive;
  logic [23:0] sinkPixel;
  int err_total = 0;
  int cmp_count = 0;
  int pixCount = 0;
  int expW = 16;
  int expH = 16;
  int stallCnt = 0;

  demosaic_if #(.SAMPLE_BIT_WIDTH(8)) link ();
  demosaic_dev #(.SAMPLE_BIT_WIDTH(8), .LINE_WIDTH(32), .LINESTORE_ADDR_BITS(AB)) u_demosaic_dev (
    .ref_clk(ref_clk), .resetn(resetn), .link(link), .frameActive(frameActive));
  demosaic_ext #(.LINESTORE_ADDR_BITS(AB)) u_demosaic_ext (
    .ref_clk(ref_clk), .resetn(resetn), .link(link), .srcSample(srcSample), .srcValid(srcValid),
    .srcReady(srcReady), .cfgWidth(cfgWidth), .cfgHeight(cfgHeight), .sinkPixel(sinkPixel),
    .sinkFrame(sinkFrame), .sinkLine(sinkLine), .sinkStrobe(sinkStrobe), .sinkReady(sinkReady),
    .resetAdvised(resetAdvised), .lineTooLong(lineTooLong));
  demosaic_asserts #(.SAMPLE_BIT_WIDTH(8)) u_demosaic_asserts (
    .ref_clk(ref_clk), .resetn(resetn), .inSample(link.inSample), .inFrame(link.inFrame),
    .inLine(link.inLine), .inValid(link.inValid), .inReady(link.inReady), .frameWidth(link.frameWidth),
    .outPixel(link.outPixel), .outFrame(link.outFrame), .outLine(link.outLine),
    .outValid(link.outValid), .outReady(link.outReady));

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  // ===========================================================
  // helpers
  task complete_run();
    $display("errors %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'h1) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // mosaic with one flat level per colour, blue at the origin
  function logic [7:0] mos(input int x, input int y);
    return (y % 2) ? ((x % 2) ? RV : GV) : ((x % 2) ? GV : BV);
  endfunction

  // called at edge+1; returns at edge+1 after the sample was taken
  task send(input logic [7:0] v);
    srcSample = v;
    srcValid = 1'h1;
    #1;
    while (srcReady !== 1'h1) begin
      @(posedge ref_clk);
      #2;
    end
    @(posedge ref_clk);
    #1;
  endtask

  task run_frame(input int w, input int h, input logic stall);
    cfgWidth = DIM_BITS'(w);
    cfgHeight = DIM_BITS'(h);
    expW = w;
    expH = h;
    pixCount = 0;
    stallMode = stall;
    for (int y = 0; y < h; y++) for (int x = 0; x < w; x++) send(mos(x, y));
    srcValid = 1'h0;
    for (int i = 0; i < 4000 && pixCount < w * h; i++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    #1;
    check(pixCount == w * h, "pixel count per frame");
    stallMode = 1'h0;
  endtask

  // ===========================================================
  // sink side
  always @(posedge ref_clk) begin
    #1;
    stallCnt++;
    sinkReady = !stallMode || (stallCnt % 3 != 0);
  end

  always @(posedge ref_clk) begin
    if (sinkStrobe === 1'h1) begin
      check(sinkFrame === (pixCount == 0), "output frame marker");
      check(sinkLine === (pixCount % expW == 0), "output line marker");
      if (pixCount % expW >= 2 && pixCount % expW <= expW - 3 && pixCount / expW >= 2 && pixCount / expW <= expH - 3)
        check(sinkPixel === {RV, GV, BV}, "interior pixel colour");
      pixCount++;
    end
  end

  // ===========================================================
  // scenarios
  task t_idle();
    repeat (30) @(posedge ref_clk);
    #1;
    check(pixCount == 0 && frameActive === 1'h0, "output without input frame");
  endtask

  task t_mid_reset();
    pixCount = 0;
    cfgWidth = 17'h00010;
    cfgHeight = 17'h00010;
    expW = 16;
    expH = 16;
    for (int i = 0; i < 40; i++) send(mos(i % 16, i / 16));
    srcValid = 1'h0;
    check(frameActive === 1'h1, "frame not active mid frame");
    resetn = 1'h0;
    repeat (10) @(posedge ref_clk);
    #1;
    // pixels of the cut frame that left before reset do not count
    pixCount = 0;
    resetn = 1'h1;
    repeat (5) @(posedge ref_clk);
    #1;
    check(pixCount == 0, "output from a frame cut by reset");
    run_frame(16, 16, 1'h0);
  endtask

  task t_line_limit();
    cfgWidth = 17'h00021;
    repeat (3) @(posedge ref_clk);
    #1;
    check(lineTooLong === 1'h1, "width above line store not flagged");
    cfgWidth = 17'h00020;
    repeat (3) @(posedge ref_clk);
    #1;
    check(lineTooLong === 1'h0, "full line store width flagged");
    run_frame(32, 16, 1'h0);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    resetn = 1'h1;
    t_idle();
    run_frame(16, 16, 1'h0);
    check(resetAdvised === 1'h0, "reset advised without change");
    run_frame(20, 17, 1'h1);
    check(resetAdvised === 1'h1, "dimension change not flagged");
    t_mid_reset();
    t_line_limit();
    complete_run();
  end
endmodule
